// >>> stpc_defs.vh
// Constants for the switch time-out and parity checker
`ifndef STPC_DEFS_VH
`define STPC_DEFS_VH
`define STPC_ADDR_W 8
`define STPC_OFS_CTRL 8'h00
`define STPC_OFS_TO_STATUS 8'h04
`define STPC_OFS_TO_COUNTS 8'h08
`define STPC_OFS_TO_REPORT 8'h0c
`define STPC_OFS_PAR_STATUS 8'h10
`define STPC_OFS_PAR_COUNT 8'h14
`define STPC_OFS_PAR_REPORT 8'h18
`define STPC_CTRL_TO_DIS 0
`define STPC_CTRL_CHK_DIS 1
`define STPC_CTRL_INJECT 2
`define STPC_CTRL_LEN_LSB 16
`define STPC_CTRL_LEN_MSB 25
`define STPC_RPT_NONE 3'h0
`define STPC_RPT_COR 3'h1
`define STPC_RPT_NONFATAL 3'h2
`define STPC_RPT_FATAL 3'h3
`define STPC_RPT_UR 3'h4
`define STPC_SEV_COR 2'h0
`define STPC_SEV_NONFATAL 2'h1
`define STPC_SEV_FATAL 2'h2
`define STPC_TO_REPORT_RST 16'h2002
`define STPC_PAR_REPORT_RST 3'h2
`define STPC_TIMEOUT_SEC 16'h0040
`define STPC_CLK_PERIOD_NS 10
`define STPC_SECOND_NS 1000000000
`define STPC_SEC_CYCLES (`STPC_SECOND_NS / `STPC_CLK_PERIOD_NS)
`endif

// >>> stpc_dw_parity.v
// Even parity of one doubleword with optional inversion
`timescale 1ns/100ps
`default_nettype none
module stpc_dw_parity (
    input wire [31:0] i_data,
    input wire i_flip,
    output wire o_par
);
    assign o_par = (^i_data) ^ i_flip;
endmodule // stpc_dw_parity
`default_nettype wire

// >>> stpc_top.v
// Switch queue time-out discard and end-to-end parity checker
`timescale 1ns/100ps
`default_nettype none
`include "stpc_defs.vh"
module stpc_top #(
    parameter SEC_CYCLES = `STPC_SEC_CYCLES
) (
    input wire I_SYS_CLK,
    input wire I_NRST,
    input wire [7:0] I_ADDR,
    input wire [31:0] I_WDATA,
    input wire I_WR,
    input wire I_RD,
    output wire [31:0] O_RDATA,
    input wire I_SYSTEM_ERROR_ENABLE,
    input wire I_CORRECTABLE_REPORT_ENABLE,
    input wire I_NONFATAL_REPORT_ENABLE,
    input wire I_FATAL_REPORT_ENABLE,
    input wire I_UNSUPPORTED_REQ_REPORT_ENABLE,
    output wire [15:0] O_AGE_STAMP,
    input wire I_HEAD_VALID,
    input wire [1:0] I_HEAD_TYPE,
    input wire [15:0] I_HEAD_STAMP,
    input wire I_HEAD_BCAST,
    output wire O_HEAD_DISCARD,
    output wire O_BCAST_ABORT,
    input wire I_RX_VALID,
    input wire I_RX_SOP,
    input wire I_RX_EOP,
    input wire [31:0] I_RX_DATA,
    input wire [9:0] I_RX_LEN,
    input wire I_RX_LCRC_ERR,
    output wire O_CORE_VALID,
    output wire O_CORE_SOP,
    output wire O_CORE_EOP,
    output wire [31:0] O_CORE_DATA,
    output wire O_CORE_PAR,
    output wire O_CORE_DROP,
    output wire O_RX_REPLAY_REQ,
    input wire I_MOD_VALID,
    input wire [31:0] I_MOD_OLD,
    input wire [31:0] I_MOD_NEW,
    input wire I_MOD_PAR,
    output wire O_MOD_PAR,
    input wire I_TX_VALID,
    input wire I_TX_EOP,
    input wire [31:0] I_TX_DATA,
    input wire I_TX_PAR,
    input wire [31:0] I_TX_LCRC,
    output wire O_TX_END_VALID,
    output wire [31:0] O_TX_LCRC,
    output wire O_TX_EDB,
    input wire I_GEN_VALID,
    input wire [31:0] I_GEN_DATA,
    output wire O_GEN_VALID,
    output wire [31:0] O_GEN_DATA,
    output wire O_GEN_PAR,
    input wire I_CONS_VALID,
    input wire I_CONS_EOP,
    input wire [31:0] I_CONS_DATA,
    input wire I_CONS_PAR,
    output wire O_CONS_ACCEPT,
    output wire O_CONS_DISCARD,
    output wire O_MSG_VALID,
    output wire [1:0] O_MSG_SEVERITY,
    output wire [2:0] O_MSG_SOURCE
);
    reg to_dis_reg, chk_dis_reg, inject_reg, par_status_reg, rx_inj_reg, mod_par_reg, tx_err_reg, tx_end_reg;
    reg core_valid_reg, core_sop_reg, core_eop_reg, core_par_reg, core_drop_reg, replay_reg, tx_edb_reg;
    reg gen_valid_reg, gen_par_reg, cons_err_reg, cons_acc_reg, cons_disc_reg, msg_valid_reg, pick_ok;
    reg [1:0] msg_sev_reg;
    reg [2:0] par_report_reg, msg_src_reg, pick;
    reg [2:0] sev_reg [0:4];
    reg [3:0] to_status_reg, to_status_next;
    reg [4:0] pend_reg, pend_next;
    reg [7:0] par_count_reg;
    reg [9:0] len_reg;
    reg [15:0] to_report_reg, sec_reg;
    reg [31:0] rdata_reg, to_counts_reg, to_counts_next, tick_cnt_reg;
    reg [31:0] core_data_reg, tx_lcrc_reg, gen_data_reg, rd_mux;
    integer k;
    integer j;
    wire wr_ctrl = I_WR && (I_ADDR == `STPC_OFS_CTRL);
    wire wr_to_sts = I_WR && (I_ADDR == `STPC_OFS_TO_STATUS);
    wire rd_to_cnt = I_RD && (I_ADDR == `STPC_OFS_TO_COUNTS);
    wire wr_to_rpt = I_WR && (I_ADDR == `STPC_OFS_TO_REPORT);
    wire wr_par_sts = I_WR && (I_ADDR == `STPC_OFS_PAR_STATUS);
    wire rd_par_cnt = I_RD && (I_ADDR == `STPC_OFS_PAR_COUNT);
    wire wr_par_rpt = I_WR && (I_ADDR == `STPC_OFS_PAR_REPORT);
    wire [15:0] head_age = sec_reg - I_HEAD_STAMP;
    wire drop = I_HEAD_VALID && !to_dis_reg && (head_age > `STPC_TIMEOUT_SEC);
    wire [3:0] drop_vec = drop ? (4'h1 << I_HEAD_TYPE) : 4'h0;
    wire rx_par, mod_par, tx_par, gen_par, cons_par;
    wire [4:0] rpt_en = {I_UNSUPPORTED_REQ_REPORT_ENABLE, I_FATAL_REPORT_ENABLE, I_NONFATAL_REPORT_ENABLE,
        I_CORRECTABLE_REPORT_ENABLE, I_SYSTEM_ERROR_ENABLE};
    wire rx_inj = I_RX_SOP ? (inject_reg && (I_RX_LEN == len_reg)) : rx_inj_reg;
    wire tx_cur_err = I_TX_VALID && !chk_dis_reg && (tx_par != I_TX_PAR);
    wire tx_pkt_err = tx_err_reg || tx_cur_err;
    wire cons_cur_err = I_CONS_VALID && !chk_dis_reg && (cons_par != I_CONS_PAR);
    wire cons_pkt_err = cons_err_reg || cons_cur_err;
    wire par_evt = (I_TX_VALID && I_TX_EOP && tx_pkt_err) || (I_CONS_VALID && I_CONS_EOP && cons_pkt_err);
    wire par_status_next = par_evt || (par_status_reg && !(wr_par_sts && I_WDATA[0]));

    // Message gate: field value masked by the report enables
    function [2:0] gate;
        input [2:0] fld;
        input [4:0] en;
        begin
            case (fld)
                `STPC_RPT_COR: gate = {en[1], `STPC_SEV_COR};
                `STPC_RPT_NONFATAL: gate = {en[2] | en[0], `STPC_SEV_NONFATAL};
                `STPC_RPT_FATAL: gate = {en[3] | en[0], `STPC_SEV_FATAL};
                `STPC_RPT_UR: gate = {en[4], `STPC_SEV_NONFATAL};
                default: gate = 3'h0;
            endcase
        end
    endfunction

    stpc_dw_parity u_rx_par (
        .i_data(I_RX_DATA),
        .i_flip(rx_inj),
        .o_par(rx_par)
    );
    stpc_dw_parity u_mod_par (
        .i_data(I_MOD_OLD ^ I_MOD_NEW),
        .i_flip(I_MOD_PAR),
        .o_par(mod_par)
    );
    stpc_dw_parity u_tx_par (
        .i_data(I_TX_DATA),
        .i_flip(1'b0),
        .o_par(tx_par)
    );
    stpc_dw_parity u_gen_par (
        .i_data(I_GEN_DATA),
        .i_flip(1'b0),
        .o_par(gen_par)
    );
    stpc_dw_parity u_cons_par (
        .i_data(I_CONS_DATA),
        .i_flip(1'b0),
        .o_par(cons_par)
    );

    // Status and saturating counters
    always @* begin
        to_status_next = drop_vec | (to_status_reg & ~(wr_to_sts ? I_WDATA[3:0] : 4'h0));
        to_counts_next = rd_to_cnt ? 32'h0 : to_counts_reg;
        for (k = 0; k < 4; k = k + 1) begin
            if (drop_vec[k] && (to_counts_next[k*8 +: 8] != 8'hff)) begin
                to_counts_next[k*8 +: 8] = to_counts_next[k*8 +: 8] + 8'h01;
            end
        end
    end

    // Pending messages, one issued per cycle, lowest source first
    always @* begin
        for (j = 0; j < 4; j = j + 1) begin
            sev_reg[j] = gate(to_report_reg[j*4 +: 3], rpt_en);
        end
        sev_reg[4] = gate(par_report_reg, rpt_en);
        pick = 3'h0;
        pick_ok = 1'b0;
        for (j = 4; j >= 0; j = j - 1) begin
            if (pend_reg[j]) begin
                pick = j[2:0];
                pick_ok = 1'b1;
            end
        end
        pend_next = pend_reg;
        if (pick_ok) begin
            pend_next[pick] = 1'b0;
        end
        for (j = 0; j < 4; j = j + 1) begin
            if (drop_vec[j] && !to_status_reg[j] && sev_reg[j][2]) begin
                pend_next[j] = 1'b1;
            end
        end
        if (par_evt && !par_status_reg && sev_reg[4][2]) begin
            pend_next[4] = 1'b1;
        end
    end

    always @* begin
        case (I_ADDR)
            `STPC_OFS_CTRL: rd_mux = {6'h0, len_reg, 13'h0, inject_reg, chk_dis_reg, to_dis_reg};
            `STPC_OFS_TO_STATUS: rd_mux = {28'h0, to_status_reg};
            `STPC_OFS_TO_COUNTS: rd_mux = to_counts_reg;
            `STPC_OFS_TO_REPORT: rd_mux = {16'h0, to_report_reg & 16'h7777};
            `STPC_OFS_PAR_STATUS: rd_mux = {31'h0, par_status_reg};
            `STPC_OFS_PAR_COUNT: rd_mux = {24'h0, par_count_reg};
            `STPC_OFS_PAR_REPORT: rd_mux = {29'h0, par_report_reg};
            default: rd_mux = 32'h0;
        endcase
    end

    // Register file
    always @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rdata_reg <= 32'h0;
            to_dis_reg <= 1'b0;
            chk_dis_reg <= 1'b0;
            inject_reg <= 1'b0;
            len_reg <= 10'h0;
            to_status_reg <= 4'h0;
            to_counts_reg <= 32'h0;
            to_report_reg <= `STPC_TO_REPORT_RST;
            par_status_reg <= 1'b0;
            par_count_reg <= 8'h0;
            par_report_reg <= `STPC_PAR_REPORT_RST;
        end else begin
            rdata_reg <= I_RD ? rd_mux : 32'h0;
            if (wr_ctrl) begin
                to_dis_reg <= I_WDATA[`STPC_CTRL_TO_DIS];
                chk_dis_reg <= I_WDATA[`STPC_CTRL_CHK_DIS];
                inject_reg <= I_WDATA[`STPC_CTRL_INJECT];
                len_reg <= I_WDATA[`STPC_CTRL_LEN_MSB:`STPC_CTRL_LEN_LSB];
            end
            if (wr_to_rpt) begin
                to_report_reg <= I_WDATA[15:0] & 16'h7777;
            end
            if (wr_par_rpt) begin
                par_report_reg <= I_WDATA[2:0];
            end
            to_status_reg <= to_status_next;
            to_counts_reg <= to_counts_next;
            par_status_reg <= par_status_next;
            if (rd_par_cnt) begin
                par_count_reg <= par_evt ? 8'h01 : 8'h00;
            end else if (par_evt && (par_count_reg != 8'hff)) begin
                par_count_reg <= par_count_reg + 8'h01;
            end
        end
    end

    // Seconds timebase for queue age stamps
    always @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            tick_cnt_reg <= 32'h0;
            sec_reg <= 16'h0;
        end else if (tick_cnt_reg == SEC_CYCLES - 1) begin
            tick_cnt_reg <= 32'h0;
            sec_reg <= sec_reg + 16'h0001;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
        end
    end

    // Data path stages
    always @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rx_inj_reg <= 1'b0;
            core_valid_reg <= 1'b0;
            core_sop_reg <= 1'b0;
            core_eop_reg <= 1'b0;
            core_data_reg <= 32'h0;
            core_par_reg <= 1'b0;
            core_drop_reg <= 1'b0;
            replay_reg <= 1'b0;
            mod_par_reg <= 1'b0;
            tx_err_reg <= 1'b0;
            tx_end_reg <= 1'b0;
            tx_lcrc_reg <= 32'h0;
            tx_edb_reg <= 1'b0;
            gen_valid_reg <= 1'b0;
            gen_data_reg <= 32'h0;
            gen_par_reg <= 1'b0;
            cons_err_reg <= 1'b0;
            cons_acc_reg <= 1'b0;
            cons_disc_reg <= 1'b0;
            pend_reg <= 5'h0;
            msg_valid_reg <= 1'b0;
            msg_sev_reg <= 2'h0;
            msg_src_reg <= 3'h0;
        end else begin
            if (I_RX_VALID) begin
                rx_inj_reg <= rx_inj;
            end
            core_valid_reg <= I_RX_VALID;
            core_sop_reg <= I_RX_VALID && I_RX_SOP;
            core_eop_reg <= I_RX_VALID && I_RX_EOP;
            if (I_RX_VALID) begin
                core_data_reg <= I_RX_DATA;
                core_par_reg <= rx_par;
            end
            core_drop_reg <= I_RX_VALID && I_RX_EOP && I_RX_LCRC_ERR;
            replay_reg <= I_RX_VALID && I_RX_EOP && I_RX_LCRC_ERR;
            if (I_MOD_VALID) begin
                mod_par_reg <= mod_par;
            end
            if (I_TX_VALID) begin
                tx_err_reg <= I_TX_EOP ? 1'b0 : tx_pkt_err;
            end
            tx_end_reg <= I_TX_VALID && I_TX_EOP;
            if (I_TX_VALID && I_TX_EOP) begin
                tx_lcrc_reg <= tx_pkt_err ? ~I_TX_LCRC : I_TX_LCRC;
                tx_edb_reg <= tx_pkt_err;
            end
            gen_valid_reg <= I_GEN_VALID;
            if (I_GEN_VALID) begin
                gen_data_reg <= I_GEN_DATA;
                gen_par_reg <= gen_par;
            end
            if (I_CONS_VALID) begin
                cons_err_reg <= I_CONS_EOP ? 1'b0 : cons_pkt_err;
            end
            cons_acc_reg <= I_CONS_VALID && I_CONS_EOP && !cons_pkt_err;
            cons_disc_reg <= I_CONS_VALID && I_CONS_EOP && cons_pkt_err;
            pend_reg <= pend_next;
            msg_valid_reg <= pick_ok;
            if (pick_ok) begin
                msg_sev_reg <= sev_reg[pick][1:0];
                msg_src_reg <= pick;
            end
        end
    end

    assign O_RDATA = rdata_reg;
    assign O_AGE_STAMP = sec_reg;
    assign O_HEAD_DISCARD = drop;
    assign O_BCAST_ABORT = drop && I_HEAD_BCAST;
    assign O_CORE_VALID = core_valid_reg;
    assign O_CORE_SOP = core_sop_reg;
    assign O_CORE_EOP = core_eop_reg;
    assign O_CORE_DATA = core_data_reg;
    assign O_CORE_PAR = core_par_reg;
    assign O_CORE_DROP = core_drop_reg;
    assign O_RX_REPLAY_REQ = replay_reg;
    assign O_MOD_PAR = mod_par_reg;
    assign O_TX_END_VALID = tx_end_reg;
    assign O_TX_LCRC = tx_lcrc_reg;
    assign O_TX_EDB = tx_edb_reg;
    assign O_GEN_VALID = gen_valid_reg;
    assign O_GEN_DATA = gen_data_reg;
    assign O_GEN_PAR = gen_par_reg;
    assign O_CONS_ACCEPT = cons_acc_reg;
    assign O_CONS_DISCARD = cons_disc_reg;
    assign O_MSG_VALID = msg_valid_reg;
    assign O_MSG_SEVERITY = msg_sev_reg;
    assign O_MSG_SOURCE = msg_src_reg;
endmodule // stpc_top
`default_nettype wire

// >>> stpc_props.sv
// Assertion checker for the time-out and parity block
`timescale 1ns/100ps
`default_nettype none
module stpc_props #(
    parameter SEC_CYCLES = 4
) (
    input wire logic I_SYS_CLK,
    input wire logic I_NRST,
    input wire logic I_HEAD_VALID,
    input wire logic [15:0] I_HEAD_STAMP,
    input wire logic I_HEAD_BCAST,
    input wire logic [15:0] O_AGE_STAMP,
    input wire logic O_HEAD_DISCARD,
    input wire logic O_BCAST_ABORT,
    input wire logic I_RX_VALID,
    input wire logic I_RX_EOP,
    input wire logic I_RX_LCRC_ERR,
    input wire logic O_RX_REPLAY_REQ,
    input wire logic O_CORE_DROP,
    input wire logic I_MOD_VALID,
    input wire logic [31:0] I_MOD_OLD,
    input wire logic [31:0] I_MOD_NEW,
    input wire logic I_MOD_PAR,
    input wire logic O_MOD_PAR,
    input wire logic I_GEN_VALID,
    input wire logic [31:0] I_GEN_DATA,
    input wire logic O_GEN_VALID,
    input wire logic O_GEN_PAR,
    input wire logic I_TX_VALID,
    input wire logic I_TX_EOP,
    input wire logic [31:0] I_TX_LCRC,
    input wire logic O_TX_END_VALID,
    input wire logic [31:0] O_TX_LCRC,
    input wire logic O_TX_EDB
);
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_NRST);
    a_stale_discard:
    assert property (O_HEAD_DISCARD |-> I_HEAD_VALID && 16'(O_AGE_STAMP - I_HEAD_STAMP) > 16'h0040)
        else $error("young packet discarded");
    a_bcast_abort:
    assert property (O_BCAST_ABORT == (O_HEAD_DISCARD && I_HEAD_BCAST))
        else $error("broadcast abort wrong");
    a_replay_request:
    assert property (I_RX_VALID && I_RX_EOP && I_RX_LCRC_ERR |=> O_RX_REPLAY_REQ && O_CORE_DROP)
        else $error("no replay on bad link check");
    a_no_replay:
    assert property (I_RX_VALID && I_RX_EOP && !I_RX_LCRC_ERR |=> !O_RX_REPLAY_REQ)
        else $error("replay on clean packet");
    a_mod_update:
    assert property (I_MOD_VALID |=> O_MOD_PAR == $past(I_MOD_PAR ^ (^I_MOD_OLD) ^ (^I_MOD_NEW)))
        else $error("parity not updated");
    a_mod_hold:
    assert property (!I_MOD_VALID |=> $stable(O_MOD_PAR))
        else $error("parity changed without edit");
    a_gen_parity:
    assert property (I_GEN_VALID |=> O_GEN_VALID && O_GEN_PAR == ^$past(I_GEN_DATA))
        else $error("produced parity wrong");
    a_tx_crc:
    assert property (I_TX_VALID && I_TX_EOP |=> O_TX_END_VALID && O_TX_LCRC == ($past(I_TX_LCRC) ^ {32{O_TX_EDB}}))
        else $error("egress end wrong");
endmodule // stpc_props
`default_nettype wire

// >>> stpc_queue_model.sv
// Ingress queue head model for the time-out path
`timescale 1ns/100ps
`default_nettype none
module stpc_queue_model (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_push,
    input wire logic [1:0] i_type,
    input wire logic i_bcast,
    input wire logic [15:0] i_age_stamp,
    input wire logic i_discard,
    output logic o_head_valid,
    output logic [1:0] o_head_type,
    output logic [15:0] o_head_stamp,
    output logic o_head_bcast
);
    // Stamp on entry, pop on discard, scramble the freed head
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            {o_head_valid, o_head_type, o_head_stamp, o_head_bcast} <= '0;
        end else if (i_push) begin
            {o_head_valid, o_head_type, o_head_stamp, o_head_bcast} <= {1'b1, i_type, i_age_stamp, i_bcast};
        end else if (i_discard) begin
            {o_head_valid, o_head_stamp, o_head_bcast} <= {1'b0, ~o_head_stamp, ~o_head_bcast};
        end
    end
endmodule // stpc_queue_model
`default_nettype wire

// >>> stpc_tb.sv
// Self-checking testbench for the time-out and parity block
`timescale 1ns/100ps
`default_nettype none
`include "stpc_defs.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED %0t %h %h", $time, g, e); end end
module testbench;
    logic I_SYS_CLK, I_NRST, I_WR, I_RD, I_RX_VALID, I_RX_SOP, I_RX_EOP, I_RX_LCRC_ERR, I_MOD_VALID, I_MOD_PAR;
    logic I_TX_VALID, I_TX_EOP, I_TX_PAR, I_GEN_VALID, I_CONS_VALID, I_CONS_EOP, I_CONS_PAR, q_push, q_bcast;
    logic I_SYSTEM_ERROR_ENABLE, I_CORRECTABLE_REPORT_ENABLE, I_NONFATAL_REPORT_ENABLE, I_FATAL_REPORT_ENABLE;
    logic I_UNSUPPORTED_REQ_REPORT_ENABLE, I_HEAD_VALID, I_HEAD_BCAST, O_HEAD_DISCARD, O_BCAST_ABORT, O_CORE_PAR;
    logic [31:0] I_WDATA, I_RX_DATA, I_MOD_OLD, I_MOD_NEW, I_TX_DATA, I_TX_LCRC, I_GEN_DATA, I_CONS_DATA, O_RDATA;
    logic [31:0] O_TX_LCRC, O_GEN_DATA, O_CORE_DATA;
    logic [15:0] O_AGE_STAMP, I_HEAD_STAMP;
    logic [9:0] I_RX_LEN;
    logic [7:0] I_ADDR;
    logic [2:0] O_MSG_SOURCE;
    logic [1:0] I_HEAD_TYPE, O_MSG_SEVERITY, q_type;
    logic O_CORE_DROP, O_RX_REPLAY_REQ, O_MOD_PAR, O_TX_END_VALID, O_TX_EDB, O_GEN_VALID, O_GEN_PAR;
    logic O_CONS_ACCEPT, O_CONS_DISCARD, O_MSG_VALID, O_CORE_VALID, O_CORE_SOP, O_CORE_EOP;
    logic [4:0] msgs[$];
    int fails = 0;
    int n_compared = 0;
    stpc_top #(.SEC_CYCLES(4)) dut (
        .I_SYS_CLK, .I_NRST, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .I_SYSTEM_ERROR_ENABLE,
        .I_CORRECTABLE_REPORT_ENABLE, .I_NONFATAL_REPORT_ENABLE, .I_FATAL_REPORT_ENABLE,
        .I_UNSUPPORTED_REQ_REPORT_ENABLE, .O_AGE_STAMP, .I_HEAD_VALID, .I_HEAD_TYPE, .I_HEAD_STAMP,
        .I_HEAD_BCAST, .O_HEAD_DISCARD, .O_BCAST_ABORT, .I_RX_VALID, .I_RX_SOP, .I_RX_EOP, .I_RX_DATA,
        .I_RX_LEN, .I_RX_LCRC_ERR, .O_CORE_VALID, .O_CORE_SOP, .O_CORE_EOP, .O_CORE_DATA, .O_CORE_PAR,
        .O_CORE_DROP, .O_RX_REPLAY_REQ, .I_MOD_VALID, .I_MOD_OLD, .I_MOD_NEW, .I_MOD_PAR, .O_MOD_PAR,
        .I_TX_VALID, .I_TX_EOP, .I_TX_DATA, .I_TX_PAR, .I_TX_LCRC, .O_TX_END_VALID, .O_TX_LCRC, .O_TX_EDB,
        .I_GEN_VALID, .I_GEN_DATA, .O_GEN_VALID, .O_GEN_DATA, .O_GEN_PAR, .I_CONS_VALID, .I_CONS_EOP,
        .I_CONS_DATA, .I_CONS_PAR, .O_CONS_ACCEPT, .O_CONS_DISCARD, .O_MSG_VALID, .O_MSG_SEVERITY, .O_MSG_SOURCE);
    stpc_queue_model u_queue (.i_clk(I_SYS_CLK), .i_nrst(I_NRST), .i_push(q_push), .i_type(q_type),
        .i_bcast(q_bcast), .i_age_stamp(O_AGE_STAMP), .i_discard(O_HEAD_DISCARD), .o_head_valid(I_HEAD_VALID),
        .o_head_type(I_HEAD_TYPE), .o_head_stamp(I_HEAD_STAMP), .o_head_bcast(I_HEAD_BCAST));
    initial begin
        I_SYS_CLK = 1'b0;
        forever #5 I_SYS_CLK = ~I_SYS_CLK;
    end
    always @(posedge I_SYS_CLK) if (O_MSG_VALID === 1'b1) msgs.push_back({O_MSG_SEVERITY, O_MSG_SOURCE});
    task stop_test;
        $display("Compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge I_SYS_CLK) {I_WR, I_ADDR, I_WDATA} <= {1'b1, a, d};
        @(posedge I_SYS_CLK) I_WR <= 1'b0;
    endtask
    task rdc(input [7:0] a, input [31:0] e);
        @(posedge I_SYS_CLK) {I_RD, I_ADDR} <= {1'b1, a};
        @(posedge I_SYS_CLK) I_RD <= 1'b0;
        #1 `CHK(O_RDATA, e)
    endtask
    task mchk(input int n, input [4:0] e);
        repeat (6) @(posedge I_SYS_CLK);
        `CHK(msgs.size(), n)
        if (n > 0) `CHK(msgs[0], e)
        msgs.delete();
    endtask
    task push(input [1:0] t, input b);
        @(posedge I_SYS_CLK) {q_push, q_type, q_bcast} <= {1'b1, t, b};
        @(posedge I_SYS_CLK) q_push <= 1'b0;
    endtask
    task t_defaults;
        rdc(`STPC_OFS_CTRL, 32'h0);
        rdc(`STPC_OFS_TO_REPORT, 32'h0000_2002);
        rdc(`STPC_OFS_PAR_REPORT, 32'h2);
        rdc(8'h1c, 32'h0);
    endtask
    task t_timeout;
        int n;
        for (int t = 0; t < 5; t++) begin
            push(2'(t % 4), t == 3);
            n = 0;
            #1;
            while (O_HEAD_DISCARD !== 1'b1 && n < 400) @(posedge I_SYS_CLK) #1 n++;
            `CHK(n > 250 && n < 270, 1'b1)
            `CHK(O_BCAST_ABORT, t == 3)
            mchk(t == 0 || t == 3, {2'h1, 3'(t)});
        end
        rdc(`STPC_OFS_TO_STATUS, 32'hf);
        rdc(`STPC_OFS_TO_COUNTS, 32'h0101_0102);
        rdc(`STPC_OFS_TO_COUNTS, 32'h0);
    endtask
    task t_to_off;
        wr(`STPC_OFS_CTRL, 32'h1);
        push(2'h2, 1'b0);
        repeat (300) @(negedge I_SYS_CLK) `CHK(O_HEAD_DISCARD, 1'b0)
        wr(`STPC_OFS_CTRL, 32'h0);
        wr(`STPC_OFS_TO_STATUS, 32'hf);
        rdc(`STPC_OFS_TO_STATUS, 32'h0);
        rdc(`STPC_OFS_TO_COUNTS, 32'h0001_0000);
    endtask
    task rx(input [31:0] d, input [9:0] len, input err, input flip);
        @(posedge I_SYS_CLK) {I_RX_VALID, I_RX_SOP, I_RX_EOP, I_RX_DATA, I_RX_LEN} <= {3'b110, d, len};
        @(posedge I_SYS_CLK) {I_RX_SOP, I_RX_EOP, I_RX_DATA, I_RX_LCRC_ERR} <= {2'b01, 32'h1, err};
        #1 `CHK(O_CORE_PAR, ^d ^ flip)
        `CHK({O_CORE_VALID, O_CORE_SOP, O_CORE_EOP, O_CORE_DATA}, {3'b110, d})
        @(posedge I_SYS_CLK) I_RX_VALID <= 1'b0;
        #1 `CHK(O_CORE_PAR, ~flip)
        `CHK(O_RX_REPLAY_REQ, err)
        `CHK({O_CORE_VALID, O_CORE_SOP, O_CORE_EOP, O_CORE_DROP, O_CORE_DATA}, {3'b101, err, 32'h1})
    endtask
    task tx(input p0, input bad);
        @(posedge I_SYS_CLK) {I_TX_VALID, I_TX_EOP, I_TX_DATA, I_TX_PAR} <= {2'b10, 32'h3, p0};
        @(posedge I_SYS_CLK) {I_TX_EOP, I_TX_DATA, I_TX_PAR, I_TX_LCRC} <= {1'b1, 32'h1, 1'b1, 32'h5a5a_1234};
        @(posedge I_SYS_CLK) I_TX_VALID <= 1'b0;
        #1 `CHK(O_TX_EDB, bad)
        `CHK(O_TX_LCRC, 32'h5a5a_1234 ^ {32{bad}})
    endtask
    task t_parity;
        wr(`STPC_OFS_CTRL, 32'h0005_0004);
        rx(32'h1234_5671, 10'd5, 1'b0, 1'b1);
        rx(32'h1234_5671, 10'd6, 1'b1, 1'b0);
        wr(`STPC_OFS_CTRL, 32'h0);
        tx(1'b0, 1'b0);
        tx(1'b1, 1'b1);
        mchk(1, 5'h0c);
        tx(1'b1, 1'b1);
        mchk(0, 5'h0);
        rdc(`STPC_OFS_PAR_STATUS, 32'h1);
        rdc(`STPC_OFS_PAR_COUNT, 32'h2);
        wr(`STPC_OFS_CTRL, 32'h2);
        tx(1'b1, 1'b0);
        wr(`STPC_OFS_CTRL, 32'h0);
        rdc(`STPC_OFS_PAR_COUNT, 32'h0);
        repeat (256) tx(1'b1, 1'b1);
        rdc(`STPC_OFS_PAR_COUNT, 32'hff);
        for (int c = 0; c < 5; c++) begin
            wr(`STPC_OFS_PAR_STATUS, 32'h1);
            wr(`STPC_OFS_PAR_REPORT, c);
            tx(1'b1, 1'b1);
            mchk(c != 0, {c == 3 ? 2'h2 : 2'(c != 1), 3'h4});
        end
        @(posedge I_SYS_CLK);
        {I_SYSTEM_ERROR_ENABLE, I_NONFATAL_REPORT_ENABLE, I_CORRECTABLE_REPORT_ENABLE} <= 3'b000;
        for (int c = 1; c < 3; c++) begin
            wr(`STPC_OFS_PAR_STATUS, 32'h1);
            wr(`STPC_OFS_PAR_REPORT, c);
            tx(1'b1, 1'b1);
            mchk(0, 5'h0);
        end
        {I_SYSTEM_ERROR_ENABLE, I_NONFATAL_REPORT_ENABLE, I_CORRECTABLE_REPORT_ENABLE} <= 3'b111;
    endtask
    task t_misc;
        @(posedge I_SYS_CLK) {I_MOD_VALID, I_MOD_OLD, I_MOD_NEW, I_MOD_PAR} <= {1'b1, 32'h1, 32'h3, 1'b0};
        @(posedge I_SYS_CLK) {I_MOD_VALID, I_GEN_VALID, I_GEN_DATA} <= {1'b0, 1'b1, 32'h7};
        #1 `CHK(O_MOD_PAR, 1'b1)
        @(posedge I_SYS_CLK) {I_GEN_VALID, I_CONS_VALID, I_CONS_DATA, I_CONS_PAR} <= {2'b01, 32'h7, 1'b1};
        #1 `CHK(O_GEN_PAR, 1'b1)
        `CHK({O_GEN_VALID, O_GEN_DATA}, {1'b1, 32'h7})
        @(posedge I_SYS_CLK) I_CONS_PAR <= 1'b0;
        #1 `CHK(O_CONS_ACCEPT, 1'b1)
        @(posedge I_SYS_CLK) I_CONS_VALID <= 1'b0;
        #1 `CHK(O_CONS_DISCARD, 1'b1)
        `CHK(O_CONS_ACCEPT, 1'b0)
    endtask
    initial begin
        {I_NRST, I_WR, I_RD, I_RX_VALID, I_RX_SOP, I_RX_EOP, I_RX_LCRC_ERR, I_MOD_VALID, I_MOD_PAR} = '0;
        {I_TX_VALID, I_TX_EOP, I_TX_PAR, I_GEN_VALID, I_CONS_VALID, I_CONS_PAR, q_push, q_bcast, q_type} = '0;
        {I_WDATA, I_RX_DATA, I_MOD_OLD, I_MOD_NEW, I_TX_DATA, I_TX_LCRC, I_GEN_DATA, I_CONS_DATA} = '0;
        {I_RX_LEN, I_ADDR, I_CONS_EOP} = 19'h1;
        {I_SYSTEM_ERROR_ENABLE, I_CORRECTABLE_REPORT_ENABLE, I_NONFATAL_REPORT_ENABLE, I_FATAL_REPORT_ENABLE,
            I_UNSUPPORTED_REQ_REPORT_ENABLE} = 5'h1f;
        repeat (5) @(posedge I_SYS_CLK);
        I_NRST <= 1'b1;
        t_defaults;
        t_timeout;
        t_to_off;
        t_parity;
        t_misc;
        stop_test;
    end
    initial begin
        #200000;
        fails++;
        stop_test;
    end
endmodule // testbench
bind stpc_top stpc_props #(.SEC_CYCLES(SEC_CYCLES)) u_props (.I_SYS_CLK, .I_NRST, .I_HEAD_VALID, .I_HEAD_STAMP,
    .I_HEAD_BCAST, .O_AGE_STAMP, .O_HEAD_DISCARD, .O_BCAST_ABORT, .I_RX_VALID, .I_RX_EOP, .I_RX_LCRC_ERR,
    .O_RX_REPLAY_REQ, .O_CORE_DROP, .I_MOD_VALID, .I_MOD_OLD, .I_MOD_NEW, .I_MOD_PAR, .O_MOD_PAR, .I_GEN_VALID,
    .I_GEN_DATA, .O_GEN_VALID, .O_GEN_PAR, .I_TX_VALID, .I_TX_EOP, .I_TX_LCRC, .O_TX_END_VALID, .O_TX_LCRC,
    .O_TX_EDB);
`default_nettype wire
